// *** src/spt_pkg.sv ***
// constants, register map and setting encodings of the scaled pulse totaliser
package spt_pkg;

	// ***************************************************
	// register port geometry
	// ***************************************************
	localparam int ADDR_W = 4; // word index width of the register port
	localparam int DATA_W = 32; // register data width

	// ***************************************************
	// register offsets (word index on the register port)
	// ***************************************************
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0; // mode, direction, rounding, point
	localparam logic [ADDR_W-1:0] OFS_PPS = 4'h1; // pulses_per_step (divisor)
	localparam logic [ADDR_W-1:0] OFS_SCALE = 4'h2; // scale (multiplier)
	localparam logic [ADDR_W-1:0] OFS_DRND = 4'h3; // display rounding step
	localparam logic [ADDR_W-1:0] OFS_CMD = 4'h4; // write-only command strobes
	localparam logic [ADDR_W-1:0] OFS_DISP = 4'h5; // presented value, signed
	localparam logic [ADDR_W-1:0] OFS_WHOLE = 4'h6; // accumulated whole counts, signed
	localparam logic [ADDR_W-1:0] OFS_FRAC = 4'h7; // fractional remainder numerator
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8; // block state flags

	// ***************************************************
	// field positions
	// ***************************************************
	localparam int CTRL_MODE_LSB = 0; // 2 bits, totaliser_mode select
	localparam int CTRL_DIR_LSB = 2; // 2 bits, direction select
	localparam int CTRL_RND_BIT = 4; // 1 = round to nearest, 0 = truncate
	localparam int CTRL_DP_LSB = 5; // 3 bits, decimal places
	localparam int CTRL_DP_W = 3; // width of the point field
	localparam int CMD_TOT_RST_BIT = 0; // clear total and remainder
	localparam int CMD_CFG_RST_BIT = 1; // restore setting defaults except mode, which keeps its value
	localparam int STAT_BUSY_BIT = 0; // divider running
	localparam int STAT_CHECK_BIT = 1; // scale needs review after point change
	localparam int STAT_PEND_BIT = 2; // pulses waiting to be applied
	localparam int STAT_STALE_BIT = 3; // step quotient being recomputed

	// ***************************************************
	// setting encodings
	// ***************************************************
	typedef enum logic [1:0] {
		SPT_MODE_RATE,
		SPT_MODE_TOTAL,
		SPT_MODE_BOTH
	} spt_mode_e;

	typedef enum logic [1:0] {
		SPT_DIR_UP,
		SPT_DIR_DOWN,
		SPT_DIR_LINE
	} spt_dir_e;

	// ***************************************************
	// reset values and limits
	// ***************************************************
	localparam logic [DATA_W-1:0] PPS_DEF = 32'h0000_0001;
	localparam logic [DATA_W-1:0] SCALE_DEF = 32'h0000_0001;
	localparam logic [DATA_W-1:0] DRND_DEF = 32'h0000_0001;
	localparam logic [DATA_W-1:0] DRND_MIN = 32'h0000_0001;
	localparam logic [DATA_W-1:0] DRND_MAX = 32'h0000_1388; // 5000 units
	localparam logic [CTRL_DP_W-1:0] DP_DEF = 3'h0;
	localparam logic RND_DEF = 1'b0; // truncation

endpackage

// *** src/spt_top.sv ***
// scaled pulse totaliser: accumulation, scaling, rounding and register port
//
// How it works
// - total grows by pulses times scale over pps
// - pps setting is divisor, default one
// - scale setting is multiplier, default one
// - display rounding step 1 to 5000 units
// - nearest mode rounds half count upward
// - truncation shows count only when complete, but below zero a count shows once begun
// - up direction adds each pulse
// - down direction subtracts each pulse
// - line mode takes direction from input two
// - decimal places from none to digits minus one
// - point change flags scale for review
// - point, pps, truncation writable only totalising
//
// Design decisions made here: the address-and-strobe port and the register addresses.
module spt_top #(
	parameter int W = 32, // accumulator and divider width
	parameter int DIGITS = 4, // digits on the display
	parameter int PEND_W = 16 // width of the pending pulse counter
) (
	// clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_N_IN,
	// pulse source
	input wire logic PULSE_IN,
	input wire logic DIR_LINE_IN,
	// register port
	input wire logic [spt_pkg::ADDR_W-1:0] ADDR_IN,
	input wire logic [spt_pkg::DATA_W-1:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [spt_pkg::DATA_W-1:0] RDATA_OUT,
	// display
	output logic [W-1:0] DISP_VALUE_OUT,
	output logic [spt_pkg::CTRL_DP_W-1:0] DP_POS_OUT,
	output logic DISP_BUSY_OUT
);

	// ***************************************************
	// state types
	// ***************************************************
	typedef enum logic {
		ST_IDLE,
		ST_DIV
	} spt_fsm_e;

	typedef struct packed {
		spt_pkg::spt_mode_e mode; // totaliser_mode select
		spt_pkg::spt_dir_e dir; // direction select
		logic nearest; // round to nearest when set
		logic [spt_pkg::CTRL_DP_W-1:0] dp; // decimal places
		logic [W-1:0] pps; // pulses_per_step
		logic [W-1:0] scale; // scale multiplier
		logic [W-1:0] drnd; // display rounding step
		logic [W-1:0] whole; // signed whole counts
		logic [W-1:0] frac; // remainder numerator, below pps
		logic [W-1:0] step_q; // scale div pps
		logic [W-1:0] step_r; // scale mod pps
		logic step_dirty; // step values need recomputing
		logic scale_check; // point moved since scale last written
		logic [PEND_W-1:0] pending; // signed pulses not yet applied
		logic pulse_prev; // last pulse level, for edge finding
		spt_fsm_e fsm; // divider sequencer
		logic div_for_step; // divider works on step, else display
		logic [7:0] div_cnt; // remaining divider bits
		logic [W-1:0] div_num; // dividend shifting into quotient
		logic [W-1:0] div_den; // divisor
		logic [W:0] div_rem; // partial remainder
		logic div_neg; // sign of value being rounded
		logic [W-1:0] disp; // presented value
		logic [spt_pkg::DATA_W-1:0] rdata; // read answer
	} spt_state_s;

	spt_state_s s_reg; // registered state
	spt_state_s s_next; // next state

	// ***************************************************
	// helpers
	// ***************************************************
	// magnitude of a signed word
	function automatic logic [W-1:0] spt_abs(input logic [W-1:0] v);
		spt_abs = v[W-1] ? W'(-v) : v;
	endfunction

	// signed word from magnitude and sign
	function automatic logic [W-1:0] spt_sign(input logic neg, input logic [W-1:0] m);
		spt_sign = neg ? W'(-m) : m;
	endfunction

	// settings that only exist while totalising
	function automatic logic spt_tot_active(input spt_pkg::spt_mode_e m);
		spt_tot_active = (m == spt_pkg::SPT_MODE_TOTAL) || (m == spt_pkg::SPT_MODE_BOTH);
	endfunction

	// ***************************************************
	// next state
	// ***************************************************
	logic pulse_edge; // rising edge of the pulse line
	logic count_up; // chosen direction for new pulses
	logic apply_en; // one pending pulse applied this cycle
	logic apply_up; // direction of the applied pulse
	logic [W:0] frac_sum; // widened remainder arithmetic
	logic [W:0] rem_try; // divider trial remainder
	logic [W-1:0] v_round; // whole count after half rounding
	logic [W-1:0] base; // magnitude rounded down to the step
	logic [W:0] twice; // doubled remainder for half tests
	logic [W-1:0] wval; // write data at accumulator width
	logic [spt_pkg::CTRL_DP_W-1:0] wdp; // point field of the write
	logic [1:0] wmode; // mode field of the write
	logic [1:0] wdir; // direction field of the write

	// whole block update: pulses, sequencer, register port
	always_comb begin
		s_next = s_reg;
		s_next.rdata = '0;
		s_next.pulse_prev = PULSE_IN;
		pulse_edge = PULSE_IN & ~s_reg.pulse_prev;
		wval = W'(WDATA_IN);
		wdp = WDATA_IN[spt_pkg::CTRL_DP_LSB +: spt_pkg::CTRL_DP_W];
		wmode = WDATA_IN[spt_pkg::CTRL_MODE_LSB +: 2];
		wdir = WDATA_IN[spt_pkg::CTRL_DIR_LSB +: 2];
		frac_sum = '0;
		rem_try = '0;
		v_round = '0;
		base = '0;
		twice = '0;

		// direction: fixed up, fixed down, or the level of input two
		unique case (s_reg.dir)
			spt_pkg::SPT_DIR_UP: count_up = 1'b1;
			spt_pkg::SPT_DIR_DOWN: count_up = 1'b0;
			spt_pkg::SPT_DIR_LINE: count_up = DIR_LINE_IN;
			default: count_up = 1'b1;
		endcase

		// new pulses join the signed pending count; rate mode ignores them
		if (pulse_edge && spt_tot_active(s_reg.mode)) begin
			s_next.pending = count_up ? s_reg.pending + 1'b1 : s_reg.pending - 1'b1;
		end

		// apply one pending pulse per cycle while step values are valid;
		// pulses wait rather than use a stale quotient
		apply_en = (s_reg.pending != '0) && !s_reg.step_dirty &&
			!(s_reg.fsm == ST_DIV && s_reg.div_for_step);
		apply_up = !s_reg.pending[PEND_W-1];
		if (apply_en) begin
			// undo this pulse from pending, keeping any arrival this cycle
			s_next.pending = apply_up ? s_next.pending - 1'b1 : s_next.pending + 1'b1;
			if (apply_up) begin
				// whole += q, frac += r, carry when frac reaches pps
				frac_sum = {1'b0, s_reg.frac} + {1'b0, s_reg.step_r};
				if (frac_sum >= {1'b0, s_reg.pps}) begin
					s_next.frac = W'(frac_sum - {1'b0, s_reg.pps});
					s_next.whole = s_reg.whole + s_reg.step_q + 1'b1;
				end else begin
					s_next.frac = W'(frac_sum);
					s_next.whole = s_reg.whole + s_reg.step_q;
				end
			end else begin
				// whole -= q, frac -= r, borrow when frac goes below zero
				frac_sum = {1'b0, s_reg.frac} - {1'b0, s_reg.step_r};
				if (frac_sum[W]) begin
					s_next.frac = W'(frac_sum + {1'b0, s_reg.pps});
					s_next.whole = s_reg.whole - s_reg.step_q - 1'b1;
				end else begin
					s_next.frac = W'(frac_sum);
					s_next.whole = s_reg.whole - s_reg.step_q;
				end
			end
		end

		// ***************************************************
		// shared restoring divider
		// ***************************************************
		unique case (s_reg.fsm)
			ST_IDLE: begin
				s_next.div_cnt = 8'(W);
				s_next.div_rem = '0;
				s_next.fsm = ST_DIV;
				if (s_reg.step_dirty) begin
					// scale over pps, once per setting change
					s_next.step_dirty = 1'b0;
					s_next.div_for_step = 1'b1;
					s_next.div_num = s_reg.scale;
					s_next.div_den = s_reg.pps;
				end else begin
					// presentation pass; the stored total is left untouched
					twice = {s_reg.frac, 1'b0};
					v_round = (s_reg.nearest && twice >= {1'b0, s_reg.pps}) ?
						s_reg.whole + 1'b1 : s_reg.whole;
					s_next.div_for_step = 1'b0;
					s_next.div_neg = v_round[W-1];
					s_next.div_num = spt_abs(v_round);
					s_next.div_den = s_reg.drnd;
				end
			end
			ST_DIV: begin
				// one quotient bit per cycle, W cycles per division
				rem_try = {s_reg.div_rem[W-1:0], s_reg.div_num[W-1]};
				if (rem_try >= {1'b0, s_reg.div_den}) begin
					s_next.div_rem = rem_try - {1'b0, s_reg.div_den};
					s_next.div_num = {s_reg.div_num[W-2:0], 1'b1};
				end else begin
					s_next.div_rem = rem_try;
					s_next.div_num = {s_reg.div_num[W-2:0], 1'b0};
				end
				s_next.div_cnt = s_reg.div_cnt - 1'b1;
				if (s_reg.div_cnt == 8'h01) begin
					s_next.fsm = ST_IDLE;
					if (s_reg.div_for_step) begin
						s_next.step_q = s_next.div_num;
						s_next.step_r = W'(s_next.div_rem);
					end else begin
						// magnitude minus remainder is a multiple of the step
						base = W'(s_next.div_num * s_reg.div_den);
						twice = {W'(s_next.div_rem), 1'b0};
						if (s_reg.nearest && twice >= {1'b0, s_reg.div_den}) begin
							base = base + s_reg.div_den;
						end
						// truncation keeps the lower multiple: no round up
						s_next.disp = spt_sign(s_reg.div_neg, base);
					end
				end
			end
			default: s_next.fsm = ST_IDLE;
		endcase

		// ***************************************************
		// register writes
		// ***************************************************
		if (WR_IN) begin
			unique case (ADDR_IN)
				spt_pkg::OFS_CTRL: begin
					// mode value three is not a mode and is ignored
					if (wmode <= 2'(spt_pkg::SPT_MODE_BOTH)) begin
						s_next.mode = spt_pkg::spt_mode_e'(wmode);
					end
					if (wdir <= 2'(spt_pkg::SPT_DIR_LINE)) begin
						s_next.dir = spt_pkg::spt_dir_e'(wdir);
					end
					if (spt_tot_active(s_reg.mode)) begin
						s_next.nearest = WDATA_IN[spt_pkg::CTRL_RND_BIT];
						// places limited to one fewer than the digits
						if (wdp <= spt_pkg::CTRL_DP_W'(DIGITS - 1)) begin
							s_next.dp = wdp;
							if (wdp != s_reg.dp) begin
								s_next.scale_check = 1'b1;
							end
						end
					end
				end
				spt_pkg::OFS_PPS: begin
					// zero would leave the scaling undefined
					if (spt_tot_active(s_reg.mode) && wval != '0) begin
						s_next.pps = wval;
						s_next.frac = '0;
						s_next.step_dirty = 1'b1;
					end
				end
				spt_pkg::OFS_SCALE: begin
					s_next.scale = wval;
					s_next.step_dirty = 1'b1;
					s_next.scale_check = 1'b0;
				end
				spt_pkg::OFS_DRND: begin
					// out-of-range steps are pulled to the nearest limit
					if (wval < W'(spt_pkg::DRND_MIN)) begin
						s_next.drnd = W'(spt_pkg::DRND_MIN);
					end else if (wval > W'(spt_pkg::DRND_MAX)) begin
						s_next.drnd = W'(spt_pkg::DRND_MAX);
					end else begin
						s_next.drnd = wval;
					end
				end
				spt_pkg::OFS_CMD: begin
					if (WDATA_IN[spt_pkg::CMD_TOT_RST_BIT]) begin
						// pulses not yet applied belong to the old total
						s_next.whole = '0;
						s_next.frac = '0;
						s_next.pending = '0;
					end
					if (WDATA_IN[spt_pkg::CMD_CFG_RST_BIT]) begin
						s_next.dir = spt_pkg::SPT_DIR_UP;
						s_next.nearest = spt_pkg::RND_DEF;
						s_next.dp = spt_pkg::DP_DEF;
						s_next.pps = W'(spt_pkg::PPS_DEF);
						s_next.scale = W'(spt_pkg::SCALE_DEF);
						s_next.drnd = W'(spt_pkg::DRND_DEF);
						s_next.frac = '0;
						s_next.scale_check = 1'b0;
						s_next.step_dirty = 1'b1;
					end
				end
				default: begin
					// unmapped and read-only offsets ignore writes
				end
			endcase
		end

		// ***************************************************
		// register reads, answered in the next cycle
		// ***************************************************
		if (RD_IN) begin
			unique case (ADDR_IN)
				spt_pkg::OFS_CTRL: begin
					s_next.rdata[spt_pkg::CTRL_MODE_LSB +: 2] = s_reg.mode;
					s_next.rdata[spt_pkg::CTRL_DIR_LSB +: 2] = s_reg.dir;
					s_next.rdata[spt_pkg::CTRL_RND_BIT] = s_reg.nearest;
					s_next.rdata[spt_pkg::CTRL_DP_LSB +: spt_pkg::CTRL_DP_W] = s_reg.dp;
				end
				spt_pkg::OFS_PPS: s_next.rdata = spt_pkg::DATA_W'(s_reg.pps);
				spt_pkg::OFS_SCALE: s_next.rdata = spt_pkg::DATA_W'(s_reg.scale);
				spt_pkg::OFS_DRND: s_next.rdata = spt_pkg::DATA_W'(s_reg.drnd);
				spt_pkg::OFS_DISP: s_next.rdata = spt_pkg::DATA_W'(s_reg.disp);
				spt_pkg::OFS_WHOLE: s_next.rdata = spt_pkg::DATA_W'(s_reg.whole);
				spt_pkg::OFS_FRAC: s_next.rdata = spt_pkg::DATA_W'(s_reg.frac);
				spt_pkg::OFS_STATUS: begin
					s_next.rdata[spt_pkg::STAT_BUSY_BIT] = (s_reg.fsm == ST_DIV);
					s_next.rdata[spt_pkg::STAT_CHECK_BIT] = s_reg.scale_check;
					s_next.rdata[spt_pkg::STAT_PEND_BIT] = (s_reg.pending != '0);
					s_next.rdata[spt_pkg::STAT_STALE_BIT] = s_reg.step_dirty |
						(s_reg.fsm == ST_DIV && s_reg.div_for_step);
				end
				default: s_next.rdata = '0; // command and unmapped read zero
			endcase
		end
	end

	// ***************************************************
	// state register
	// ***************************************************
	// constant reset values only; step recomputed right after release
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			s_reg <= '0;
			s_reg.mode <= spt_pkg::SPT_MODE_TOTAL;
			s_reg.dir <= spt_pkg::SPT_DIR_UP;
			s_reg.nearest <= spt_pkg::RND_DEF;
			s_reg.dp <= spt_pkg::DP_DEF;
			s_reg.pps <= W'(spt_pkg::PPS_DEF);
			s_reg.scale <= W'(spt_pkg::SCALE_DEF);
			s_reg.drnd <= W'(spt_pkg::DRND_DEF);
			s_reg.step_dirty <= 1'b1;
			s_reg.fsm <= ST_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ***************************************************
	// outputs
	// ***************************************************
	assign RDATA_OUT = s_reg.rdata;
	assign DISP_VALUE_OUT = s_reg.disp;
	assign DP_POS_OUT = s_reg.dp;
	assign DISP_BUSY_OUT = (s_reg.fsm == ST_DIV);

endmodule

// *** tb/spt_asserts.sv ***
// checker of the scaled pulse totaliser top-level port behaviour
module spt_asserts #(
	parameter int W = 32, // accumulator width
	parameter int DIGITS = 4, // display digits
	parameter int PEND_W = 16 // pending counter width
) (
	// clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_N_IN,
	// pulse source
	input wire logic PULSE_IN,
	input wire logic DIR_LINE_IN,
	// register port
	input wire logic [spt_pkg::ADDR_W-1:0] ADDR_IN,
	input wire logic [spt_pkg::DATA_W-1:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic [spt_pkg::DATA_W-1:0] RDATA_OUT,
	// display
	input wire logic [W-1:0] DISP_VALUE_OUT,
	input wire logic [spt_pkg::CTRL_DP_W-1:0] DP_POS_OUT,
	input wire logic DISP_BUSY_OUT
);
	// ***************************************************
	// common clocking
	// ***************************************************
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	// ***************************************************
	// assertions
	// ***************************************************
	// read data only in the cycle after a read strobe
	rdata_idle_a: assert property (!RD_IN |=> RDATA_OUT == '0)
		else $error("read data not zero outside a read answer");
	// mode and direction never hold the refused code 3
	ctrl_codes_a: assert property (RD_IN && ADDR_IN == spt_pkg::OFS_CTRL |=>
		RDATA_OUT[1:0] != 2'h3 && RDATA_OUT[3:2] != 2'h3)
		else $error("control holds a refused mode or direction code");
	// point field read back equals the point shown
	dp_mirror_a: assert property (RD_IN && ADDR_IN == spt_pkg::OFS_CTRL |=>
		RDATA_OUT[7:5] == DP_POS_OUT)
		else $error("point field differs from point output");
	// places never reach the digit count
	dp_range_a: assert property (DP_POS_OUT <= DIGITS - 1)
		else $error("decimal places beyond digits minus one");
	// point moves only after a control write or a command
	dp_cause_a: assert property (!$stable(DP_POS_OUT) |-> $past(WR_IN) &&
		($past(ADDR_IN) == spt_pkg::OFS_CTRL || $past(ADDR_IN) == spt_pkg::OFS_CMD))
		else $error("point changed without a write");
	// divisor can never read back as zero
	pps_nonzero_a: assert property (RD_IN && ADDR_IN == spt_pkg::OFS_PPS |=>
		RDATA_OUT != '0)
		else $error("pulses per step read as zero");
	// rounding step always within 1 to 5000
	drnd_range_a: assert property (RD_IN && ADDR_IN == spt_pkg::OFS_DRND |=>
		RDATA_OUT >= 32'h0000_0001 && RDATA_OUT <= 32'h0000_1388)
		else $error("rounding step outside its range");
	// a division pass lasts more than a handful of cycles
	busy_min_a: assert property ($rose(DISP_BUSY_OUT) |-> DISP_BUSY_OUT [*8])
		else $error("divider busy too short");
	// command word is write only
	cmd_read_a: assert property (RD_IN && ADDR_IN == spt_pkg::OFS_CMD |=>
		RDATA_OUT == '0)
		else $error("command word read not zero");

	// ***************************************************
	// coverage of main scenarios
	// ***************************************************
	pulse_c: cover property ($rose(PULSE_IN));
	dp_max_c: cover property (DP_POS_OUT == 3'h3);
	neg_c: cover property (DISP_VALUE_OUT[W-1]);
endmodule

bind spt_top spt_asserts #(.W(W), .DIGITS(DIGITS), .PEND_W(PEND_W)) spt_asserts_inst (
	.SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .PULSE_IN(PULSE_IN),
	.DIR_LINE_IN(DIR_LINE_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
	.RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .DISP_VALUE_OUT(DISP_VALUE_OUT),
	.DP_POS_OUT(DP_POS_OUT), .DISP_BUSY_OUT(DISP_BUSY_OUT));

// *** tb/spt_pulse_src.sv ***
// model of the external pulse source and direction line
module spt_pulse_src (
	// clock
	input wire logic clk_in,
	// lines to the totaliser
	output logic pulse_out,
	output logic dir_line_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ***************************************************
	// idle levels
	// ***************************************************
	initial begin
		pulse_out = 1'b0; // pulse line rests low between bursts
		dir_line_out = 1'b1; // up until told otherwise
	end

	// ***************************************************
	// burst of n pulses, gap low cycles between them
	// ***************************************************
	// gap of 1 is the fastest legal rate; larger gaps model a slow source
	task automatic send(input int n, input int gap, input logic up);
		@(posedge clk_in);
		dir_line_out <= up;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in);
			pulse_out <= 1'b1;
			@(posedge clk_in);
			pulse_out <= 1'b0;
			repeat (gap - 1) @(posedge clk_in);
		end
		repeat (2) @(posedge clk_in);
	endtask
endmodule

// *** tb/spt_top_tb.sv ***
// self-checking testbench of the scaled pulse totaliser
module spt_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ***************************************************
	// signals
	// ***************************************************
	logic sys_clk; // 100 MHz
	logic rst_n; // async reset, active low
	logic pulse; // from source model
	logic dir_line; // from source model
	logic [spt_pkg::ADDR_W-1:0] addr; // register index
	logic [spt_pkg::DATA_W-1:0] wdata; // write data
	logic wr; // write strobe
	logic rd; // read strobe
	logic [spt_pkg::DATA_W-1:0] rdata; // read answer
	logic [31:0] disp; // presented value
	logic [spt_pkg::CTRL_DP_W-1:0] dp_pos; // decimal places
	logic busy; // divider running
	int n_errors; // mismatches
	int n_tests; // comparisons

	// ***************************************************
	// instances
	// ***************************************************
	spt_top #(.W(32), .DIGITS(4), .PEND_W(16)) spt_top_inst (
		.SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .PULSE_IN(pulse), .DIR_LINE_IN(dir_line),
		.ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
		.DISP_VALUE_OUT(disp), .DP_POS_OUT(dp_pos), .DISP_BUSY_OUT(busy));
	spt_pulse_src spt_pulse_src_inst (.clk_in(sys_clk), .pulse_out(pulse),
		.dir_line_out(dir_line));

	// ***************************************************
	// clock
	// ***************************************************
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ***************************************************
	// helpers
	// ***************************************************
	// verdict in one place, also reached on a timeout
	task automatic give_verdict();
		if (n_errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	// answer sampled in the one cycle it stands
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd_reg(a, d);
		check(d, exp);
	endtask
	// wait for pending and stale clear, then two display passes
	task automatic settle();
		logic [31:0] s;
		int quiet;
		quiet = 0;
		for (int i = 0; i < 400 && quiet < 2; i++) begin
			rd_reg(spt_pkg::OFS_STATUS, s);
			quiet = ((s & 32'h0000_000C) == 32'h0) ? quiet + 1 : 0;
		end
		if (quiet < 2) begin
			n_errors++;
			$display("ERROR at %0t ns: timeout status %h expected %h", $time, s, 32'h0);
			give_verdict();
		end
		// the divider idles only one cycle in 33; a pass under way may still hold an old total
		repeat (70) @(negedge sys_clk);
	endtask

	// ***************************************************
	// scenarios
	// ***************************************************
	task automatic t_defaults();
		int hi;
		hi = 0;
		// one idle cycle in every 33: start plus one cycle per quotient bit
		repeat (33) begin
			@(negedge sys_clk);
			hi += int'(busy);
		end
		check(32'(hi), 32'h0000_0020);
		rd_chk(spt_pkg::OFS_CTRL, 32'h0000_0001);
		rd_chk(spt_pkg::OFS_PPS, 32'h0000_0001);
		rd_chk(spt_pkg::OFS_SCALE, 32'h0000_0001);
		rd_chk(spt_pkg::OFS_DRND, 32'h0000_0001);
	endtask
	// ten pulses per count, truncate then nearest
	task automatic t_round();
		wr_reg(spt_pkg::OFS_PPS, 32'h0000_000A);
		spt_pulse_src_inst.send(6, 1, 1'b1);
		settle();
		check(disp, 32'h0);
		rd_chk(spt_pkg::OFS_FRAC, 32'h0000_0006);
		wr_reg(spt_pkg::OFS_CTRL, 32'h0000_0011);
		settle();
		check(disp, 32'h0000_0001);
		rd_chk(spt_pkg::OFS_WHOLE, 32'h0);
		spt_pulse_src_inst.send(4, 5, 1'b1);
		settle();
		rd_chk(spt_pkg::OFS_WHOLE, 32'h0000_0001);
		wr_reg(spt_pkg::OFS_CTRL, 32'h0000_0001);
		settle();
		check(disp, 32'h0000_0001);
	endtask
	// fixed down, line steered both ways, fixed up
	task automatic t_dir();
		wr_reg(spt_pkg::OFS_CMD, 32'h0000_0001);
		wr_reg(spt_pkg::OFS_PPS, 32'h0000_0001);
		wr_reg(spt_pkg::OFS_SCALE, 32'h0000_0003);
		wr_reg(spt_pkg::OFS_CTRL, 32'h0000_0005);
		spt_pulse_src_inst.send(2, 1, 1'b1);
		settle();
		rd_chk(spt_pkg::OFS_WHOLE, 32'hFFFF_FFFA);
		wr_reg(spt_pkg::OFS_CTRL, 32'h0000_0009);
		spt_pulse_src_inst.send(1, 1, 1'b1);
		settle();
		rd_chk(spt_pkg::OFS_WHOLE, 32'hFFFF_FFFD);
		spt_pulse_src_inst.send(2, 3, 1'b0);
		settle();
		rd_chk(spt_pkg::OFS_WHOLE, 32'hFFFF_FFF7);
		wr_reg(spt_pkg::OFS_CTRL, 32'h0000_0001);
		spt_pulse_src_inst.send(2, 1, 1'b0);
		settle();
		check(disp, 32'hFFFF_FFFD);
	endtask
	// rounding step of ten and its clamps
	task automatic t_drnd();
		wr_reg(spt_pkg::OFS_CMD, 32'h0000_0001);
		wr_reg(spt_pkg::OFS_SCALE, 32'h0000_0007);
		spt_pulse_src_inst.send(3, 1, 1'b1);
		wr_reg(spt_pkg::OFS_DRND, 32'h0000_000A);
		settle();
		check(disp, 32'h0000_0014);
		rd_chk(spt_pkg::OFS_WHOLE, 32'h0000_0015);
		wr_reg(spt_pkg::OFS_DRND, 32'h0);
		rd_chk(spt_pkg::OFS_DRND, 32'h0000_0001);
		wr_reg(spt_pkg::OFS_DRND, 32'h0000_1770);
		rd_chk(spt_pkg::OFS_DRND, 32'h0000_1388);
	endtask
	// point at its limit, one beyond, scale review flag
	task automatic t_point();
		logic [31:0] s;
		wr_reg(spt_pkg::OFS_CTRL, 32'h0000_0061);
		@(posedge sys_clk);
		check(dp_pos, 32'h0000_0003);
		// busy bit left out: the divider runs 32 cycles of every 33
		rd_reg(spt_pkg::OFS_STATUS, s);
		check(s & 32'hFFFF_FFFE, 32'h0000_0002);
		wr_reg(spt_pkg::OFS_CTRL, 32'h0000_0081);
		@(posedge sys_clk);
		check(dp_pos, 32'h0000_0003);
		wr_reg(spt_pkg::OFS_SCALE, 32'h0000_0001);
		settle();
		rd_reg(spt_pkg::OFS_STATUS, s);
		check(s & 32'hFFFF_FFFE, 32'h0);
	endtask
	// config reset, then rate mode refusals
	task automatic t_rate();
		wr_reg(spt_pkg::OFS_CMD, 32'h0000_0002);
		settle();
		rd_chk(spt_pkg::OFS_CTRL, 32'h0000_0001);
		wr_reg(spt_pkg::OFS_CMD, 32'h0000_0001);
		wr_reg(spt_pkg::OFS_CTRL, 32'h0);
		wr_reg(spt_pkg::OFS_PPS, 32'h0000_0005);
		rd_chk(spt_pkg::OFS_PPS, 32'h0000_0001);
		wr_reg(spt_pkg::OFS_CTRL, 32'h0000_0030);
		rd_chk(spt_pkg::OFS_CTRL, 32'h0);
		spt_pulse_src_inst.send(2, 1, 1'b1);
		settle();
		rd_chk(spt_pkg::OFS_WHOLE, 32'h0);
		wr_reg(spt_pkg::OFS_WHOLE, 32'h0000_0055);
		rd_chk(spt_pkg::OFS_WHOLE, 32'h0);
		rd_chk(4'hF, 32'h0);
		// combined mode opens the settings again; code three is refused
		wr_reg(spt_pkg::OFS_CTRL, 32'h0000_0002);
		wr_reg(spt_pkg::OFS_PPS, 32'h0000_0005);
		rd_chk(spt_pkg::OFS_PPS, 32'h0000_0005);
		wr_reg(spt_pkg::OFS_CTRL, 32'h0000_000F);
		rd_chk(spt_pkg::OFS_CTRL, 32'h0000_0002);
	endtask

	// ***************************************************
	// main sequence
	// ***************************************************
	initial begin
		n_errors = 0;
		n_tests = 0;
		rst_n = 1'b0;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_defaults();
		settle();
		t_round();
		t_dir();
		t_drnd();
		t_point();
		t_rate();
		give_verdict();
	end
endmodule
